// File: rtl/tbd_pkg.sv
// Package with register map, field layout and tap tables of the time base.
package tbd_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int PRESC_MIN_W = 23;
  localparam logic [ADDR_W-1:0] CTRL_IDX = 12'h036;
  localparam logic [ADDR_W-1:0] STAT_IDX = 12'h038;
  localparam logic [ADDR_W-1:0] MASK_IDX = 12'h039;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_IDX[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] STAT_ADDR = {STAT_IDX[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] MASK_ADDR = {MASK_IDX[ADDR_W-3:0], 2'h0};
  localparam int TONE_EN_BIT = 7;
  localparam int TONE_SEL_LSB = 5;
  localparam int SRC_BIT = 4;
  localparam int IRQ_EN_BIT = 3;
  localparam int IRQ_SEL_LSB = 0;
  localparam int EVT_PERIODIC = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [0:0] STAT_RESET = 1'h0;
  localparam logic [0:0] MASK_RESET = 1'h0;

  typedef struct packed {
    logic tone_out_enable;
    logic [1:0] tone_rate_select;
    logic prescaler_source_select;
    logic periodic_irq_enable;
    logic [2:0] periodic_rate_select;
  } tbd_ctrl_type;

  // Prescaler bit index for the periodic tap; bit k runs at tick/2^(k+1).
  function automatic logic [4:0] tbd_irq_tap(input logic src,
                                             input logic [2:0] sel);
    logic [4:0] r;
    r = 5'h00;
    if (!src) begin
      case (sel)
        3'h0: r = 5'h16;
        3'h1: r = 5'h14;
        3'h2: r = 5'h0F;
        3'h3: r = 5'h0D;
        3'h4: r = 5'h0C;
        3'h5: r = 5'h0B;
        3'h6: r = 5'h0A;
        default: r = 5'h08;
      endcase
    end else begin
      case (sel)
        3'h0: r = 5'h0E;
        3'h1: r = 5'h0C;
        3'h2: r = 5'h07;
        3'h3: r = 5'h05;
        3'h4: r = 5'h04;
        3'h5: r = 5'h03;
        3'h6: r = 5'h02;
        default: r = 5'h00;
      endcase
    end
    return r;
  endfunction

  // Prescaler bit index for the tone tap.
  function automatic logic [4:0] tbd_tone_tap(input logic src,
                                              input logic [1:0] sel);
    return src ? (5'h04 - {3'h0, sel}) : (5'h0C - {3'h0, sel});
  endfunction
endpackage

// File: rtl/tbd_time_base.sv
// Time base with periodic interrupt, tone divider output and APB slave.
//
// Function
// - Control word: tone enable 7, tone rate 6:5, source 4, irq en 3, rate 2:0.
// - Control word resets to zero, both outputs disabled.
// - Fast source rate codes pick fast clock over 2^23 down to 2^9.
// - Slow source rate codes pick slow clock over 2^15 down to 2.
// - Periodic request fires on each falling edge of selected tap.
// - Prescaler is never cleared by writes; first period may be short.
// - Enabled tone pin carries a roughly half duty square wave.
// - Tone enable bit gates the pin; readable and writable.
// - Fast source tone codes give fast clock over 2^13 to 2^10.
// - Slow source or slow modes give slow clock over 2^5 to 2^2.
`timescale 1ns/1ps
`default_nettype none
module tbd_time_base
  import tbd_pkg::*;
#(
  parameter int PRESC_W = 23
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [DATA_W-1:0] prdata,
  output logic pslverr,
  input wire logic high_freq_clock,
  input wire logic low_freq_clock,
  input wire logic slow_mode,
  output logic periodic_irq_request,
  output logic irq,
  output logic tone_out_pin_n
);

  if (PRESC_W < PRESC_MIN_W) begin : g_chk
    $error("Prescaler narrower than the deepest tap.");
  end

  typedef struct packed {
    tbd_ctrl_type ctrl;
    logic [0:0] status;
    logic [0:0] mask;
    logic [PRESC_W-1:0] presc;
    logic tone_run;
    logic pin_n;
    logic req;
    logic irq;
    logic ready;
    logic [DATA_W-1:0] rdata;
    logic slverr;
  } tbd_state_type;

  tbd_state_type st_ff;
  tbd_state_type nxt_st;
  logic src;
  logic tick;
  logic [PRESC_W-1:0] nxt_presc;
  logic [4:0] irq_idx;
  logic [4:0] tone_idx;
  logic irq_fall;
  logic tone_fall;
  logic nxt_tone_tap;
  logic xfer;
  logic wr;
  logic clr_hit;

  function automatic logic bit_at(input logic [PRESC_W-1:0] v,
                                  input logic [4:0] i);
    return v[i];
  endfunction

  always_comb begin
    nxt_st = st_ff;
    // Slow modes run the prescaler from the slow clock only.
    src = slow_mode | st_ff.ctrl.prescaler_source_select;
    tick = src ? low_freq_clock : high_freq_clock;
    nxt_presc = st_ff.presc + PRESC_W'(tick);
    irq_idx = tbd_irq_tap(src, st_ff.ctrl.periodic_rate_select);
    tone_idx = tbd_tone_tap(src, st_ff.ctrl.tone_rate_select);
    irq_fall = bit_at(st_ff.presc, irq_idx) & ~bit_at(nxt_presc, irq_idx);
    tone_fall = bit_at(st_ff.presc, tone_idx) & ~bit_at(nxt_presc, tone_idx);
    nxt_tone_tap = bit_at(nxt_presc, tone_idx);
    nxt_st.presc = nxt_presc;
    // APB: one wait cycle, the transfer completes when pready is seen high.
    xfer = psel & penable & st_ff.ready;
    wr = xfer & pwrite & pstrb[0];
    clr_hit = 1'b0;
    nxt_st.ready = psel & penable & ~st_ff.ready;
    nxt_st.slverr = 1'b0;
    nxt_st.rdata = st_ff.rdata;
    if (psel & penable & ~st_ff.ready) begin
      nxt_st.rdata = '0;
      if (paddr == CTRL_ADDR) begin
        nxt_st.rdata[7:0] = st_ff.ctrl;
      end else if (paddr == STAT_ADDR) begin
        nxt_st.rdata[0] = st_ff.status[0];
      end else if (paddr == MASK_ADDR) begin
        nxt_st.rdata[0] = st_ff.mask[0];
      end else begin
        nxt_st.slverr = 1'b1;
      end
    end
    if (wr) begin
      if (paddr == CTRL_ADDR) begin
        nxt_st.ctrl = pwdata[7:0];
      end else if (paddr == STAT_ADDR) begin
        clr_hit = pwdata[EVT_PERIODIC];
      end else if (paddr == MASK_ADDR) begin
        nxt_st.mask[0] = pwdata[EVT_PERIODIC];
      end
    end
    // A new tap edge wins over a same-cycle clear.
    nxt_st.req = st_ff.ctrl.periodic_irq_enable & irq_fall;
    if (nxt_st.req) begin
      nxt_st.status[0] = 1'b1;
    end else if (clr_hit) begin
      nxt_st.status[0] = 1'b0;
    end
    nxt_st.irq = nxt_st.status[0] & nxt_st.mask[0];
    // Tone waits for a tap falling edge so the first low phase is whole.
    if (!st_ff.ctrl.tone_out_enable) begin
      nxt_st.tone_run = 1'b0;
    end else if (tone_fall) begin
      nxt_st.tone_run = 1'b1;
    end
    nxt_st.pin_n = 1'b1;
    if (st_ff.ctrl.tone_out_enable & nxt_st.tone_run) begin
      nxt_st.pin_n = nxt_tone_tap;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.ctrl <= CTRL_RESET;
      st_ff.status <= STAT_RESET;
      st_ff.mask <= MASK_RESET;
      st_ff.pin_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pready = st_ff.ready;
  assign prdata = st_ff.rdata;
  assign pslverr = st_ff.slverr;
  assign periodic_irq_request = st_ff.req;
  assign irq = st_ff.irq;
  assign tone_out_pin_n = st_ff.pin_n;

  property p_ctrl_write;
    @(posedge pclk) disable iff (!presetn)
    wr && paddr == CTRL_ADDR |=> st_ff.ctrl == $past(pwdata[7:0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("Control word did not take the written value.");

  property p_irq_on_fall;
    @(posedge pclk) disable iff (!presetn)
    st_ff.ctrl.periodic_irq_enable && irq_fall
      |=> periodic_irq_request && st_ff.status[0];
  endproperty
  a_irq_on_fall: assert property (p_irq_on_fall)
    else $error("Tap falling edge did not raise the periodic request.");

  property p_irq_cause;
    @(posedge pclk) disable iff (!presetn)
    $rose(st_ff.status[0]) |->
      $past(st_ff.ctrl.periodic_irq_enable) && $past(irq_fall);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("Periodic status set without an enabled tap edge.");

  property p_presc_free;
    @(posedge pclk) disable iff (!presetn)
    tick |=> st_ff.presc == PRESC_W'($past(st_ff.presc) + 1'b1);
  endproperty
  a_presc_free: assert property (p_presc_free)
    else $error("Prescaler did not advance on its tick.");

  property p_tone_idle;
    @(posedge pclk) disable iff (!presetn)
    !st_ff.ctrl.tone_out_enable ##1 !st_ff.ctrl.tone_out_enable
      |-> tone_out_pin_n;
  endproperty
  a_tone_idle: assert property (p_tone_idle)
    else $error("Tone pin not idle high while disabled.");

  property p_tone_follow;
    @(posedge pclk) disable iff (!presetn)
    st_ff.ctrl.tone_out_enable && nxt_st.tone_run
      |=> tone_out_pin_n == $past(nxt_tone_tap);
  endproperty
  a_tone_follow: assert property (p_tone_follow)
    else $error("Tone pin does not follow the selected tap.");

  property p_apb_wait;
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("APB answer not after exactly one wait cycle.");

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
    st_ff.status[0] && st_ff.mask[0] && !clr_hit
      && !(wr && paddr == MASK_ADDR) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("Unmasked pending status did not hold the interrupt.");

  property p_req_pulse;
    @(posedge pclk) disable iff (!presetn)
    periodic_irq_request |=> !periodic_irq_request;
  endproperty
  a_req_pulse: assert property (p_req_pulse)
    else $error("Periodic request lasted more than one cycle.");

  property p_req_off;
    @(posedge pclk) disable iff (!presetn)
    !st_ff.ctrl.periodic_irq_enable |=> !periodic_irq_request;
  endproperty
  a_req_off: assert property (p_req_off)
    else $error("Periodic request raised while the time base is off.");

  property p_presc_hold;
    @(posedge pclk) disable iff (!presetn)
    !tick |=> st_ff.presc == $past(st_ff.presc);
  endproperty
  a_presc_hold: assert property (p_presc_hold)
    else $error("Prescaler moved without a tick.");

  property p_slow_ignores_fast;
    @(posedge pclk) disable iff (!presetn)
    slow_mode && !low_freq_clock |=> st_ff.presc == $past(st_ff.presc);
  endproperty
  a_slow_ignores_fast: assert property (p_slow_ignores_fast)
    else $error("Slow mode prescaler followed the fast clock.");

  property p_fast_irq_tap;
    @(posedge pclk) disable iff (!presetn)
    !src |-> irq_idx inside {[5'h08:5'h16]};
  endproperty
  a_fast_irq_tap: assert property (p_fast_irq_tap)
    else $error("Fast periodic tap outside its table.");

  property p_slow_irq_tap;
    @(posedge pclk) disable iff (!presetn)
    src |-> irq_idx <= 5'h0E;
  endproperty
  a_slow_irq_tap: assert property (p_slow_irq_tap)
    else $error("Slow periodic tap outside its table.");

  property p_fast_tone_tap;
    @(posedge pclk) disable iff (!presetn)
    !src |-> tone_idx inside {[5'h09:5'h0C]};
  endproperty
  a_fast_tone_tap: assert property (p_fast_tone_tap)
    else $error("Fast tone tap outside its table.");

  property p_slow_tone_tap;
    @(posedge pclk) disable iff (!presetn)
    src |-> tone_idx inside {[5'h01:5'h04]};
  endproperty
  a_slow_tone_tap: assert property (p_slow_tone_tap)
    else $error("Slow tone tap outside its table.");

  property p_err_data;
    @(posedge pclk) disable iff (!presetn)
    pslverr |-> pready && prdata == '0;
  endproperty
  a_err_data: assert property (p_err_data)
    else $error("Error answer without ready or with nonzero data.");

  property p_strb_ignored;
    @(posedge pclk) disable iff (!presetn)
    psel && penable && pready && pwrite && !pstrb[0]
      |=> $stable(st_ff.ctrl) && $stable(st_ff.mask);
  endproperty
  a_strb_ignored: assert property (p_strb_ignored)
    else $error("Write without byte strobe changed a register.");

  property p_mask_low;
    @(posedge pclk) disable iff (!presetn)
    !st_ff.mask[0] && !(wr && paddr == MASK_ADDR) |=> !irq;
  endproperty
  a_mask_low: assert property (p_mask_low)
    else $error("Masked status raised the interrupt.");

  property p_tone_start;
    @(posedge pclk) disable iff (!presetn)
    $rose(st_ff.ctrl.tone_out_enable) |-> tone_out_pin_n;
  endproperty
  a_tone_start: assert property (p_tone_start)
    else $error("Tone pin not high when the output was enabled.");

  property p_clear;
    @(posedge pclk) disable iff (!presetn)
    clr_hit && !nxt_st.req |=> !st_ff.status[0];
  endproperty
  a_clear: assert property (p_clear)
    else $error("Write of one did not clear the periodic status.");

  c_irq: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(irq));
  c_tone: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(tone_out_pin_n));
  c_clear_race: cover property (@(posedge pclk) disable iff (!presetn)
    clr_hit && nxt_st.req);
  c_tone_slow: cover property (@(posedge pclk) disable iff (!presetn)
    slow_mode && !tone_out_pin_n);

endmodule
`default_nettype wire

// File: test/tbd_core_buzzer.sv
// Core and buzzer model counting requests and tone pulses.
`timescale 1ns/1ps
`default_nettype none
module tbd_core_buzzer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic pin_n,
  output int n_req,
  output int n_tone
);
  logic last_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_req <= 0;
      n_tone <= 0;
      last_ff <= 1'b1;
    end else begin
      n_req <= n_req + int'(req === 1'b1);
      n_tone <= n_tone + int'(last_ff && pin_n === 1'b0);
      last_ff <= pin_n;
    end
  end
endmodule
`default_nettype wire

// File: test/tbd_time_base_tb.sv
// Self-checking bench for the time base against a cycle model.
`timescale 1ns/1ps
`default_nettype none
module tbd_time_base_tb;
  import tbd_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, hf, lf, slow;
  logic pready, pslverr, req, irq, pin_n, stat, mask, e_req, e_irq;
  logic e_pin, armed, e_err;
  logic [31:0] e_rd;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] ctrl;
  int failures, n_checks, cyc, cnt, n_req, n_tone, m_req, m_tone;
  int itap[16] = '{22, 20, 15, 13, 12, 11, 10, 8, 14, 12, 7, 5, 4, 3, 2, 0};
  int ttap[8] = '{12, 11, 10, 9, 4, 3, 2, 1};
  tbd_time_base #(.PRESC_W(23)) u_tbd_time_base (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .high_freq_clock(hf),
    .low_freq_clock(lf), .slow_mode(slow), .periodic_irq_request(req),
    .irq(irq), .tone_out_pin_n(pin_n));
  tbd_core_buzzer u_tbd_core_buzzer (.pclk(pclk), .presetn(presetn),
    .req(req), .pin_n(pin_n), .n_req(n_req), .n_tone(n_tone));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin : stim
    hf = 1'b0;
    lf = 1'b0;
    void'($urandom(32'hA2D05659));
    forever begin
      @(posedge pclk);
      hf <= ($urandom % 4) != 0;
      lf <= 1'($urandom % 2);
    end
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      end_of_test();
    end
  end
  always @(posedge pclk or negedge presetn) begin : model
    int n, t, u;
    logic s;
    if (!presetn) begin
      cnt = 0;
      ctrl = 8'h00;
      e_rd = 32'h0;
      {stat, mask, e_req, e_irq, armed, e_err, e_pin} = 7'h01;
    end else begin
      chk(req, e_req);
      chk(pin_n, e_pin);
      chk(irq, e_irq);
      if (psel && penable && pready) begin
        if (!pwrite) chk(prdata, e_rd);
        chk(pslverr, e_err);
      end
      if (psel && penable && !pready) begin
        e_rd = 32'h0;
        e_err = 1'b0;
        if (paddr == CTRL_ADDR) e_rd = {24'h0, ctrl};
        else if (paddr == STAT_ADDR) e_rd = {31'h0, stat};
        else if (paddr == MASK_ADDR) e_rd = {31'h0, mask};
        else e_err = 1'b1;
      end
      s = ctrl[SRC_BIT] | slow;
      n = cnt + int'(s ? lf : hf);
      t = itap[{s, ctrl[2:0]}];
      u = ttap[{s, ctrl[6:5]}];
      e_req = ctrl[IRQ_EN_BIT] && cnt[t] && !n[t];
      m_req += int'(e_req);
      armed = ctrl[TONE_EN_BIT] && (armed || (cnt[u] && !n[u]));
      m_tone += int'(e_pin && armed && !n[u]);
      e_pin = armed ? n[u] : 1'b1;
      if (psel && penable && pready && pwrite && pstrb[0]) begin
        if (paddr == CTRL_ADDR) ctrl = pwdata[7:0];
        if (paddr == STAT_ADDR && pwdata[0]) stat = 1'b0;
        if (paddr == MASK_ADDR) mask = pwdata[0];
      end
      stat = stat | e_req;
      e_irq = stat & mask;
      cnt = n;
    end
  end
  initial begin : main
    logic [31:0] r;
    logic e;
    logic [7:0] v;
    {failures, n_checks, cyc, m_req, m_tone} = '0;
    {presetn, psel, penable, pwrite, slow} = '0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTRL_ADDR, 32'h0, r, e);
    chk(r, 32'h0);
    pstrb <= 4'h0;
    apb(1'b1, CTRL_ADDR, 32'hFF, r, e);
    pstrb <= 4'hF;
    apb(1'b0, CTRL_ADDR, 32'h0, r, e);
    chk(r, 32'h0);
    apb(1'b0, 12'h100, 32'h0, r, e);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
    for (int i = 0; i < 16; i++) begin
      v = {1'b0, i[1:0], i[3], 1'b0, i[2:0]};
      slow <= i == 1;
      apb(1'b1, MASK_ADDR, {31'h0, i[0]}, r, e);
      apb(1'b1, CTRL_ADDR, {24'h0, v}, r, e);
      apb(1'b1, CTRL_ADDR, {24'h0, v | 8'h88}, r, e);
      apb(1'b0, CTRL_ADDR, 32'h0, r, e);
      chk(r, {24'h0, v | 8'h88});
      repeat (700) @(posedge pclk);
      apb(1'b0, STAT_ADDR, 32'h0, r, e);
      apb(1'b0, MASK_ADDR, 32'h0, r, e);
      apb(1'b1, STAT_ADDR, 32'h1, r, e);
      apb(1'b1, CTRL_ADDR, {24'h0, v}, r, e);
    end
    repeat (4) @(posedge pclk);
    chk(n_req, m_req);
    chk(n_tone, m_tone);
    end_of_test();
  end
endmodule
`default_nettype wire
